//--- core/pmicc_ctrl.sv
// power controller: serial slave, fault status, interrupt and reset logic
module pmicc_ctrl #(
  parameter int unsigned DEBOUNCE_CYCLES = pmicc_pkg::DEBOUNCE_CYC,
  parameter int unsigned RST_DELAY_CYCLES = pmicc_pkg::RST_DELAY_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire pmicc_pkg::pmicc_pins_s pins,
  output logic sda_o,
  output logic sda_oe,
  output logic int_o,
  output logic int_oe,
  output logic system_reset_out_o,
  output logic system_reset_out_oe,
  output logic device_on,
  output logic [4:0] core_vcode,
  output logic [2:0] regulator1_vcode,
  output logic [2:0] regulator2_vcode
);

  pmicc_pkg::pmicc_pins_s meta_reg;
  pmicc_pkg::pmicc_pins_s sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  // two-stage synchroniser; the first stage feeds only the second
  // reset to idle pin levels so no false edge or warm reset follows reset
  // two pipeline stages keep 400 kHz phases well resolved
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= '{scl: 1'b1, sda: 1'b1, warm_reset_in_n: 1'b1,
        default: '0};
      sync_reg <= '{scl: 1'b1, sda: 1'b1, warm_reset_in_n: 1'b1,
        default: '0};
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      meta_reg <= pins;
      sync_reg <= meta_reg;
      scl_prev_reg <= sync_reg.scl;
      sda_prev_reg <= sync_reg.sda;
    end
  end

  // bus edge and condition decode
  wire scl_rise = sync_reg.scl & ~scl_prev_reg;
  wire scl_fall = ~sync_reg.scl & scl_prev_reg;
  wire start_cond = sync_reg.scl & scl_prev_reg & sda_prev_reg & ~sync_reg.sda;
  wire stop_cond = sync_reg.scl & scl_prev_reg & ~sda_prev_reg & sync_reg.sda;

  // power mode follows the lockout comparator
  logic on_reg;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      on_reg <= 1'b0;
    else
      on_reg <= sync_reg.vcc_above_undervoltage_lockout;
  end

  // warm reset debounce: input must hold a new level for the whole window
  logic [23:0] deb_cnt_reg;
  logic warm_active_reg;
  wire warm_raw = ~sync_reg.warm_reset_in_n;
  wire deb_differs = warm_raw != warm_active_reg;
  wire deb_done = deb_cnt_reg == 24'(DEBOUNCE_CYCLES - 1);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      deb_cnt_reg <= '0;
      warm_active_reg <= 1'b0;
    end
    else if (!deb_differs)
      deb_cnt_reg <= '0;
    else if (deb_done)
    begin
      deb_cnt_reg <= '0;
      warm_active_reg <= warm_raw;
    end
    else
      deb_cnt_reg <= deb_cnt_reg + 24'h000001;
  end

  // system reset: held while rail low or warm reset, then delayed release
  logic [23:0] rst_cnt_reg;
  logic sys_rst_reg;
  wire rst_cause = ~on_reg | ~sync_reg.rtc_rail_good | warm_active_reg;
  wire rst_done = rst_cnt_reg == 24'(RST_DELAY_CYCLES - 1);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_cnt_reg <= '0;
      sys_rst_reg <= 1'b1;
    end
    else if (rst_cause)
    begin
      rst_cnt_reg <= '0;
      sys_rst_reg <= 1'b1;
    end
    else if (sys_rst_reg)
    begin
      if (rst_done)
        sys_rst_reg <= 1'b0;
      else
        rst_cnt_reg <= rst_cnt_reg + 24'h000001;
    end
  end

  // fault status; disabled rails and core scaling read as good
  wire [4:0] rail_fault = sync_reg.rail_below & sync_reg.rail_enabled &
    ~(5'h01 << pmicc_pkg::RAIL_CORE & {5{sync_reg.core_dvs_active}});
  wire [7:0] fault_now = {sync_reg.power_fail_below,
    sync_reg.low_battery_below, rail_fault, 1'b0};

  // serial slave registers
  pmicc_pkg::pmicc_state_e state_reg;
  pmicc_pkg::pmicc_state_e state_next;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic rw_reg;
  logic master_ack_reg;
  logic sda_oe_reg;
  logic [7:0] mask_reg;
  logic [7:0] block_reg;
  logic [4:0] core_reg;
  logic [2:0] linear_regulator_1_reg;
  logic [2:0] linear_regulator_2_reg;
  logic sel_latched_reg;
  logic core_sel_reg;
  logic [1:0] ldo_sel_reg;

  // read data selection
  wire [7:0] core_rd = {3'h0, core_reg};
  wire [7:0] ldo_rd = {1'b0, linear_regulator_2_reg, 1'b0, linear_regulator_1_reg};
  logic [7:0] rd_data;
  assign rd_data =
    (ptr_reg == pmicc_pkg::ADDR_REVISION) ? pmicc_pkg::REVISION_CODE :
    (ptr_reg == pmicc_pkg::ADDR_FAULT) ? fault_now :
    (ptr_reg == pmicc_pkg::ADDR_MASK) ? mask_reg :
    (ptr_reg == pmicc_pkg::ADDR_CORE) ? core_rd :
    (ptr_reg == pmicc_pkg::ADDR_LDO) ? ldo_rd :
    pmicc_pkg::UNMAPPED_DATA;

  // byte boundary decode
  wire byte_done = bit_cnt_reg == 4'h8;
  wire addr_match = shift_reg[7:1] == pmicc_pkg::SLAVE_ADDR;
  wire load_tx = scl_fall & ((state_reg == pmicc_pkg::ST_ACK_ADDR & rw_reg) |
    (state_reg == pmicc_pkg::ST_RACK & master_ack_reg));
  wire fault_read = load_tx & (ptr_reg == pmicc_pkg::ADDR_FAULT);
  wire wr_strobe = scl_fall & (state_reg == pmicc_pkg::ST_WDATA) & byte_done;

  // protocol sequencing, advanced on clock falls so data moves with scl low
  always_comb
  begin
    state_next = state_reg;
    if (start_cond)
      state_next = pmicc_pkg::ST_ADDR;
    else if (stop_cond | ~on_reg)
      state_next = pmicc_pkg::ST_IDLE;
    else if (scl_fall)
    begin
      case (state_reg)
        pmicc_pkg::ST_ADDR:
          if (byte_done)
            state_next = addr_match ? pmicc_pkg::ST_ACK_ADDR
              : pmicc_pkg::ST_IDLE;
        pmicc_pkg::ST_ACK_ADDR:
          state_next = rw_reg ? pmicc_pkg::ST_RDATA : pmicc_pkg::ST_REG;
        pmicc_pkg::ST_REG:
          if (byte_done)
            state_next = pmicc_pkg::ST_ACK_REG;
        pmicc_pkg::ST_ACK_REG:
          state_next = pmicc_pkg::ST_WDATA;
        pmicc_pkg::ST_WDATA:
          if (byte_done)
            state_next = pmicc_pkg::ST_ACK_WR;
        pmicc_pkg::ST_ACK_WR:
          state_next = pmicc_pkg::ST_WDATA;
        pmicc_pkg::ST_RDATA:
          if (byte_done)
            state_next = pmicc_pkg::ST_RACK;
        pmicc_pkg::ST_RACK:
          state_next = master_ack_reg ? pmicc_pkg::ST_RDATA
            : pmicc_pkg::ST_IDLE;
        default:
          state_next = pmicc_pkg::ST_IDLE;
      endcase
    end
  end

  // receive side, bits taken on clock rise
  wire rx_state = (state_reg == pmicc_pkg::ST_ADDR) |
    (state_reg == pmicc_pkg::ST_REG) | (state_reg == pmicc_pkg::ST_WDATA);
  wire cnt_clear = start_cond | (scl_fall & byte_done);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= pmicc_pkg::ST_IDLE;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      master_ack_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (cnt_clear)
        bit_cnt_reg <= '0;
      else if (scl_rise & (rx_state | state_reg == pmicc_pkg::ST_RDATA))
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (scl_rise & rx_state)
        shift_reg <= {shift_reg[6:0], sync_reg.sda};
      if (scl_rise & state_reg == pmicc_pkg::ST_RACK)
        master_ack_reg <= ~sync_reg.sda;
    end
  end

  // address, direction and pointer capture
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rw_reg <= 1'b0;
      ptr_reg <= '0;
    end
    else if (scl_fall & byte_done)
    begin
      if (state_reg == pmicc_pkg::ST_ADDR)
        rw_reg <= shift_reg[0];
      if (state_reg == pmicc_pkg::ST_REG)
        ptr_reg <= shift_reg;
    end
  end

  // data line drive: acknowledge low and read bits, changed on clock fall
  wire ack_slot = (state_next == pmicc_pkg::ST_ACK_ADDR) |
    (state_next == pmicc_pkg::ST_ACK_REG) |
    (state_next == pmicc_pkg::ST_ACK_WR);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sda_oe_reg <= 1'b0;
      tx_reg <= '0;
    end
    else if (start_cond | stop_cond | ~on_reg)
      sda_oe_reg <= 1'b0;
    else if (load_tx)
    begin
      tx_reg <= rd_data;
      sda_oe_reg <= ~rd_data[7];
    end
    else if (scl_fall)
    begin
      if (ack_slot)
        sda_oe_reg <= 1'b1;
      else if (state_reg == pmicc_pkg::ST_RDATA & ~byte_done)
      begin
        tx_reg <= {tx_reg[6:0], 1'b0};
        sda_oe_reg <= ~tx_reg[6];
      end
      else
        sda_oe_reg <= 1'b0;
    end
  end

  // mask register and read blocking; blocked bits free once fault clears
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mask_reg <= pmicc_pkg::MASK_RESET;
      block_reg <= '0;
    end
    else if (!on_reg)
    begin
      mask_reg <= pmicc_pkg::MASK_RESET;
      block_reg <= '0;
    end
    else
    begin
      // contents kept for as long as the device stays on
      if (wr_strobe & ptr_reg == pmicc_pkg::ADDR_MASK)
        mask_reg <= {shift_reg[7:1], 1'b0};
      block_reg <= (block_reg | (fault_read ? fault_now : 8'h00))
        & fault_now;
    end
  end

  // linear regulator default selects captured once per power-up; core select follows its strap
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sel_latched_reg <= 1'b0;
      core_sel_reg <= 1'b0;
      ldo_sel_reg <= '0;
    end
    else if (!on_reg)
      sel_latched_reg <= 1'b0;
    else if (!sel_latched_reg)
    begin
      sel_latched_reg <= 1'b1;
      ldo_sel_reg <= {sync_reg.regulator2_default_select,
        sync_reg.regulator1_default_select};
      core_sel_reg <= sync_reg.core_default_select;
    end
    else
      core_sel_reg <= sync_reg.core_default_select;
  end

  // linear regulator codes: defaults from selects, host may override
  // live straps until latched, so the power-up cycle loads the new select
  wire [1:0] ldo_sel_now = sel_latched_reg ? ldo_sel_reg :
    {sync_reg.regulator2_default_select, sync_reg.regulator1_default_select};
  wire [2:0] linear_regulator_1_def = pmicc_pkg::LINEAR_REGULATOR_1_DEF_TAB[3*ldo_sel_now +: 3];
  wire [2:0] linear_regulator_2_def = pmicc_pkg::LINEAR_REGULATOR_2_DEF_TAB[3*ldo_sel_now +: 3];
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      linear_regulator_1_reg <= '0;
      linear_regulator_2_reg <= '0;
    end
    else if (!sel_latched_reg)
    begin
      linear_regulator_1_reg <= linear_regulator_1_def;
      linear_regulator_2_reg <= linear_regulator_2_def;
    end
    else if (wr_strobe & ptr_reg == pmicc_pkg::ADDR_LDO)
    begin
      linear_regulator_1_reg <= shift_reg[2:0];
      linear_regulator_2_reg <= shift_reg[pmicc_pkg::LINEAR_REGULATOR_2_LSB +: 3];
    end
  end

  // core voltage: defaults win, then system-off pattern, then host writes
  wire sys_off = ~sync_reg.rail_enabled[pmicc_pkg::RAIL_SYS];
  wire core_off = ~sync_reg.rail_enabled[pmicc_pkg::RAIL_CORE];
  wire core_force_def = warm_active_reg | ~sync_reg.rtc_rail_good |
    ~on_reg | sys_rst_reg | (sys_off & core_off);
  wire [4:0] core_def = core_sel_reg ? pmicc_pkg::CORE_DEF_HIGH
    : pmicc_pkg::CORE_DEF_LOW;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      core_reg <= pmicc_pkg::CORE_DEF_LOW;
    else if (core_force_def)
      core_reg <= core_def;
    else if (sys_off)
      core_reg <= {1'b1, core_reg[3:1], 1'b0};
    else if (wr_strobe & ptr_reg == pmicc_pkg::ADDR_CORE)
      core_reg <= shift_reg[4:0];
  end

  // interrupt: low pull whenever the device is on and an unmasked, unblocked fault stands
  wire int_pull = on_reg & |(fault_now & ~mask_reg & ~block_reg);

  // registered outputs; open-drain pins only ever drive low
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      int_o <= 1'b0;
      int_oe <= 1'b0;
      system_reset_out_o <= 1'b0;
      system_reset_out_oe <= 1'b1;
      device_on <= 1'b0;
      core_vcode <= pmicc_pkg::CORE_DEF_LOW;
      regulator1_vcode <= '0;
      regulator2_vcode <= '0;
    end
    else
    begin
      sda_o <= 1'b0;
      sda_oe <= sda_oe_reg;
      int_o <= 1'b0;
      int_oe <= int_pull;
      system_reset_out_o <= 1'b0;
      system_reset_out_oe <= sys_rst_reg;
      device_on <= on_reg;
      core_vcode <= core_reg;
      regulator1_vcode <= linear_regulator_1_reg;
      regulator2_vcode <= linear_regulator_2_reg;
    end
  end

endmodule

//--- core/pmicc_pkg.sv
// shared constants, types and register map of the power controller
package pmicc_pkg;

  // serial slave address and register map
  localparam logic [6:0] SLAVE_ADDR = 7'h48;
  localparam logic [7:0] ADDR_REVISION = 8'h00;
  localparam logic [7:0] ADDR_FAULT = 8'h01;
  localparam logic [7:0] ADDR_MASK = 8'h02;
  localparam logic [7:0] ADDR_CORE = 8'h06;
  localparam logic [7:0] ADDR_LDO = 8'h07;
  localparam logic [7:0] UNMAPPED_DATA = 8'hFF;

  // value is arbitrary, not a real part revision
  localparam logic [7:0] REVISION_CODE = 8'h5A;

  // reset values
  localparam logic [7:0] MASK_RESET = 8'hC0;
  localparam logic [4:0] CORE_DEF_LOW = 5'h0A;
  localparam logic [4:0] CORE_DEF_HIGH = 5'h14;

  // linear regulator default codes, three bits per select value
  localparam logic [11:0] LINEAR_REGULATOR_1_DEF_TAB = {3'h7, 3'h5, 3'h2, 3'h0};
  localparam logic [11:0] LINEAR_REGULATOR_2_DEF_TAB = {3'h7, 3'h6, 3'h1, 3'h1};

  // fault register field positions, rail indices and the regulator 2 field offset
  localparam int FAULT_PF = 7;
  localparam int FAULT_LB = 6;
  localparam int FAULT_RAIL_LSB = 1;
  localparam int RAIL_CORE = 2;
  localparam int RAIL_SYS = 4;
  localparam int LINEAR_REGULATOR_2_LSB = 4;

  // timing
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned DEBOUNCE_MS = 30;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned RST_DELAY_MS = 100;
  localparam int unsigned RST_DELAY_CYC = (CLK_HZ / 1000) * RST_DELAY_MS;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACK_ADDR = 4'h2,
    ST_REG = 4'h3,
    ST_ACK_REG = 4'h4,
    ST_WDATA = 4'h5,
    ST_ACK_WR = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK = 4'h8
  } pmicc_state_e;

  // every asynchronous pin, synchronised as one group
  typedef struct packed {
    logic scl;
    logic sda;
    logic warm_reset_in_n;
    logic vcc_above_undervoltage_lockout;
    logic rtc_rail_good;
    logic power_fail_below;
    logic low_battery_below;
    logic [4:0] rail_below;
    logic [4:0] rail_enabled;
    logic core_dvs_active;
    logic core_default_select;
    logic regulator1_default_select;
    logic regulator2_default_select;
  } pmicc_pins_s;

endpackage

//--- tb/pmicc_ctrl_assertions.sv
// port-level checks of the power controller, bound to its top module
module pmicc_ctrl_assertions #(
  parameter int unsigned DEBOUNCE_CYCLES = 20,
  parameter int unsigned RST_DELAY_CYCLES = 30
) (
  input logic clk,
  input logic nrst,
  input pmicc_pkg::pmicc_pins_s pins,
  input logic sda_o,
  input logic sda_oe,
  input logic int_o,
  input logic int_oe,
  input logic system_reset_out_o,
  input logic system_reset_out_oe,
  input logic device_on,
  input logic [4:0] core_vcode,
  input logic [2:0] regulator1_vcode,
  input logic [2:0] regulator2_vcode
);
  int unsigned wlow_cnt;
  logic [4:0] core_def;

  // default code chosen by the strap
  assign core_def = pins.core_default_select ? pmicc_pkg::CORE_DEF_HIGH
                                             : pmicc_pkg::CORE_DEF_LOW;

  // warm reset low run length; saturates so a long hold never wraps
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      wlow_cnt <= 0;
    else if (pins.warm_reset_in_n)
      wlow_cnt <= 0;
    else if (wlow_cnt < DEBOUNCE_CYCLES + 8)
      wlow_cnt <= wlow_cnt + 1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_scl_high;
    pins.scl [*8];
  endsequence
  sequence s_rtc_low;
    !pins.rtc_rail_good [*6];
  endsequence

  property p_on;
    pins.vcc_above_undervoltage_lockout [*8] |-> device_on;
  endproperty
  a_on: assert property (p_on)
    else $error("device not on with supply above lockout");
  property p_off;
    !pins.vcc_above_undervoltage_lockout [*8] |-> !device_on && system_reset_out_oe;
  endproperty
  a_off: assert property (p_off)
    else $error("device on or reset free below lockout");
  property p_rtc;
    s_rtc_low |-> system_reset_out_oe;
  endproperty
  a_rtc: assert property (p_rtc)
    else $error("reset output free with rtc rail low");
  property p_rel;
    $fell(system_reset_out_oe) |->
      pins.rtc_rail_good && device_on && pins.warm_reset_in_n;
  endproperty
  a_rel: assert property (p_rel)
    else $error("reset output released while a cause stands");
  property p_warm;
    wlow_cnt == DEBOUNCE_CYCLES + 8 |-> system_reset_out_oe;
  endproperty
  a_warm: assert property (p_warm)
    else $error("debounced warm reset did not assert reset output");
  property p_core_def;
    s_rtc_low |-> core_vcode == core_def;
  endproperty
  a_core_def: assert property (p_core_def)
    else $error("core code not default with rtc rail low");
  property p_sys_off;
    (pins.rtc_rail_good && pins.warm_reset_in_n && !system_reset_out_oe &&
     !pins.rail_enabled[4] && pins.rail_enabled[2]) [*6]
      |-> core_vcode[4] && !core_vcode[0];
  endproperty
  a_sys_off: assert property (p_sys_off)
    else $error("core code not 1xxx0 with system converter off");
  property p_scl_hold;
    s_scl_high |-> $stable(sda_oe);
  endproperty
  a_scl_hold: assert property (p_scl_hold)
    else $error("data line moved while clock high");
endmodule

bind pmicc_ctrl pmicc_ctrl_assertions #(
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
  .RST_DELAY_CYCLES(RST_DELAY_CYCLES)
) chk (
  .clk(clk), .nrst(nrst), .pins(pins), .sda_o(sda_o), .sda_oe(sda_oe),
  .int_o(int_o), .int_oe(int_oe), .system_reset_out_o(system_reset_out_o),
  .system_reset_out_oe(system_reset_out_oe), .device_on(device_on),
  .core_vcode(core_vcode), .regulator1_vcode(regulator1_vcode),
  .regulator2_vcode(regulator2_vcode)
);

//--- tb/pmicc_host_model.sv
// serial bus master standing in for the host processor
module pmicc_host_model #(
  parameter int HALF = 50
) (
  input logic clk,
  input logic sda_line,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rd_byte;
  event rd_ev;

  // idle bus: both lines released to the pull-ups
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // data moves mid low phase, sampled at end of high phase
  task automatic bit_io(input logic b, output logic r);
    hold(HALF / 2);
    sda_low <= !b;
    hold(HALF / 2);
    scl <= 1'b1;
    hold(HALF);
    r = sda_line;
    scl <= 1'b0;
  endtask

  // msb first, then the extra clock for the acknowledge
  task automatic byte_io(input logic [7:0] tx, input logic last,
                         output logic [7:0] rx, output logic ack_n);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(last, ack_n);
  endtask

  task automatic start_c;
    sda_low <= 1'b1;
    hold(HALF);
    scl <= 1'b0;
  endtask

  task automatic stop_c;
    hold(HALF / 2);
    sda_low <= 1'b1;
    hold(HALF / 2);
    scl <= 1'b1;
    hold(HALF);
    sda_low <= 1'b0;
    hold(HALF);
  endtask

  task automatic wr(input logic [6:0] sa, input logic [7:0] ra,
                    input logic [7:0] d, output logic [2:0] nak);
    logic [7:0] x;
    start_c();
    byte_io({sa, 1'b0}, 1'b1, x, nak[2]);
    byte_io(ra, 1'b1, x, nak[1]);
    byte_io(d, 1'b1, x, nak[0]);
    stop_c();
  endtask

  // pointer write, stop, then one byte read ended by a nack
  task automatic rd(input logic [7:0] ra, output logic [2:0] nak);
    logic [7:0] x;
    start_c();
    byte_io({pmicc_pkg::SLAVE_ADDR, 1'b0}, 1'b1, x, nak[2]);
    byte_io(ra, 1'b1, x, nak[1]);
    stop_c();
    start_c();
    byte_io({pmicc_pkg::SLAVE_ADDR, 1'b1}, 1'b1, x, nak[0]);
    byte_io(8'hFF, 1'b1, rd_byte, x[0]);
    stop_c();
    ->rd_ev;
  endtask
endmodule

//--- tb/tb_pmic_control_serial_status.sv
// self-checking bench of the power controller with a bus master model
module tb_pmic_control_serial_status;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  pmicc_pkg::pmicc_pins_s pv, pins_in;
  logic sda_o, sda_oe, int_o, int_oe, rst_o, rst_oe, device_on;
  logic [4:0] core_vcode;
  logic [2:0] r1_code, r2_code;
  logic scl, sda_low;
  logic [7:0] exp_q[$];
  logic [31:0] f;
  logic [7:0] v, e;
  logic [4:0] en;
  int mismatches = 0;
  int checks_done = 0;
  wire sda_line = !(sda_low || (sda_oe && !sda_o));

  always #5 clk = ~clk;

  // wire levels overlay the bench-driven pins
  always_comb
  begin
    pins_in = pv;
    pins_in.scl = scl;
    pins_in.sda = sda_line;
  end

  pmicc_ctrl #(.DEBOUNCE_CYCLES(20), .RST_DELAY_CYCLES(30)) uut (
    .clk(clk), .nrst(nrst), .pins(pins_in), .sda_o(sda_o),
    .sda_oe(sda_oe), .int_o(int_o), .int_oe(int_oe),
    .system_reset_out_o(rst_o), .system_reset_out_oe(rst_oe),
    .device_on(device_on), .core_vcode(core_vcode),
    .regulator1_vcode(r1_code), .regulator2_vcode(r2_code)
  );
  // scl phases kept long enough for the two-stage pin sampling
  pmicc_host_model #(.HALF(50)) host (
    .clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low)
  );

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check8(input string n, input logic [7:0] ex,
                        input logic [7:0] g);
    checks_done++;
    if (g !== ex)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, ex, g);
    end
  endtask

  task automatic check1(input string n, input logic ex, input logic g);
    check8(n, {7'h0, ex}, {7'h0, g});
  endtask

  // bounded wait; a flag that never arrives ends the run
  task automatic wait_chk(input string n, ref logic s, input logic val);
    for (int i = 0; i < 2000 && s !== val; i++)
      @(posedge clk);
    check1(n, val, s);
    if (s !== val)
      stop_test();
  endtask

  task automatic wr_ok(input logic [7:0] ra, input logic [7:0] d);
    logic [2:0] nak;
    host.wr(pmicc_pkg::SLAVE_ADDR, ra, d, nak);
    check8("write ack", 8'h00, {5'h0, nak});
  endtask

  task automatic rd_exp(input logic [7:0] ra, input logic [7:0] ex);
    logic [2:0] nak;
    exp_q.push_back(ex);
    host.rd(ra, nak);
    check8("read ack", 8'h00, {5'h0, nak});
    check1("sda released", 1'b0, sda_oe);
  endtask

  // read results land here and meet the oldest expectation
  initial
  forever
  begin
    @(host.rd_ev);
    check8("read data", exp_q.pop_front(), host.rd_byte);
  end

  initial
  begin
    repeat (90000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  initial
  begin
    void'($urandom(21));
    pv = '0;
    pv.warm_reset_in_n = 1'b1;
    pv.vcc_above_undervoltage_lockout = 1'b1;
    pv.rtc_rail_good = 1'b1;
    pv.rail_enabled = 5'h1F;
    repeat (20) @(posedge clk);
    check1("reset out", 1'b1, rst_oe);
    nrst <= 1'b1;
    wait_chk("on", device_on, 1'b1);
    for (int s = 0; s < 4; s++)
    begin
      pv.regulator1_default_select <= s[0];
      pv.regulator2_default_select <= s[1];
      pv.vcc_above_undervoltage_lockout <= 1'b0;
      wait_chk("off", device_on, 1'b0);
      pv.vcc_above_undervoltage_lockout <= 1'b1;
      wait_chk("on", device_on, 1'b1);
      repeat (4) @(posedge clk);
      check8("reg1", {5'h0, pmicc_pkg::LINEAR_REGULATOR_1_DEF_TAB[3*s +: 3]}, r1_code);
      check8("reg2", {5'h0, pmicc_pkg::LINEAR_REGULATOR_2_DEF_TAB[3*s +: 3]}, r2_code);
    end
    wait_chk("reset out", rst_oe, 1'b0);
    wr_ok(pmicc_pkg::ADDR_REVISION, ~pmicc_pkg::REVISION_CODE);
    rd_exp(pmicc_pkg::ADDR_REVISION, pmicc_pkg::REVISION_CODE);
    rd_exp(8'h05, pmicc_pkg::UNMAPPED_DATA);
    f = $urandom;
    v = {1'b0, f[6:4], 1'b0, f[2:0]};
    wr_ok(pmicc_pkg::ADDR_LDO, v);
    check8("reg1", {5'h0, v[2:0]}, r1_code);
    check8("reg2", {5'h0, v[6:4]}, r2_code);
    host.wr(7'h49, pmicc_pkg::ADDR_LDO, ~v, en[2:0]);
    check8("foreign ack", 8'h07, {5'h0, en[2:0]});
    check8("reg1", {5'h0, v[2:0]}, r1_code);
    f = $urandom;
    en = {1'b1, f[10:8], 1'b1};
    pv.rail_below <= f[4:0] | 5'h01;
    pv.power_fail_below <= f[5];
    pv.low_battery_below <= f[6];
    pv.core_dvs_active <= f[7];
    pv.rail_enabled <= en;
    e = {f[5], f[6], (f[4:0] | 5'h01) & en & ~{2'b0, f[7], 2'b0}, 1'b0};
    wait_chk("int", int_oe, 1'b1);
    rd_exp(pmicc_pkg::ADDR_FAULT, e);
    wait_chk("int blocked", int_oe, 1'b0);
    pv.rail_below <= 5'h00;
    pv.core_dvs_active <= 1'b0;
    pv.rail_enabled <= 5'h1F;
    wr_ok(pmicc_pkg::ADDR_MASK, 8'hC2);
    pv.rail_below <= 5'h01;
    repeat (20) @(posedge clk);
    check1("int masked", 1'b0, int_oe);
    pv.rail_below <= 5'h02;
    wait_chk("int", int_oe, 1'b1);
    pv.rail_below <= 5'h00;
    wr_ok(pmicc_pkg::ADDR_CORE, 8'h15);
    check8("core", 8'h15, {3'h0, core_vcode});
    pv.rail_enabled[4] <= 1'b0;
    repeat (10) @(posedge clk);
    check8("core", 8'h14, {3'h0, core_vcode});
    pv.rail_enabled[2] <= 1'b0;
    repeat (10) @(posedge clk);
    check8("core", 8'h0A, {3'h0, core_vcode});
    pv.rail_enabled <= 5'h1F;
    wr_ok(pmicc_pkg::ADDR_CORE, 8'h1B);
    pv.warm_reset_in_n <= 1'b0;
    wait_chk("reset out", rst_oe, 1'b1);
    check8("core", 8'h0A, {3'h0, core_vcode});
    check8("reg1", {5'h0, v[2:0]}, r1_code);
    repeat (10) @(posedge clk);
    check1("reset out", 1'b1, rst_oe);
    pv.warm_reset_in_n <= 1'b1;
    wait_chk("reset out", rst_oe, 1'b0);
    pv.rtc_rail_good <= 1'b0;
    wait_chk("reset out", rst_oe, 1'b1);
    repeat (8) @(posedge clk);
    check8("core", 8'h0A, {3'h0, core_vcode});
    check8("pin levels", 8'h00, {5'h0, sda_o, int_o, rst_o});
    stop_test();
  end
endmodule
